// ==== core/dpr_defines.vh ====
// Offsets, fields, reset values and timing counts of the bank-state controller
`ifndef DPR_DEFINES_VH
`define DPR_DEFINES_VH
// ****************************************************************
// Register offsets
// ****************************************************************
`define DPR_REG_TIMING0   12'h000
`define DPR_REG_TIMING1   12'h004
`define DPR_REG_STATUS    12'h008
`define DPR_REG_REFCNT    12'h00c
// ****************************************************************
// Timing0 fields (clock counts)
// ****************************************************************
`define DPR_F_RAS_LSB     0
`define DPR_F_RTP_LSB     8
`define DPR_F_RP_LSB      16
`define DPR_F_WR_LSB      24
// ****************************************************************
// Timing1 fields
// ****************************************************************
`define DPR_F_AL_LSB      0
`define DPR_F_CL_LSB      8
`define DPR_F_BL8_BIT     16
`define DPR_F_FAST_BIT    17
// ****************************************************************
// Reset values
// ****************************************************************
`define DPR_RST_TIMING0   32'h03_04_02_09
`define DPR_RST_TIMING1   32'h0000_0303
// ****************************************************************
// Timing constants
// ****************************************************************
`define DPR_CLK_NS        50
`define DPR_TREFI_NS      7800
`define DPR_TREFI_CYC     (`DPR_TREFI_NS / `DPR_CLK_NS)
`define DPR_FREQ_WAIT     2
`define DPR_REF_LIMIT     16'h057c
`endif

// ==== core/dpr_bank.v ====
// One DRAM bank: open-row state and its precharge timers
`timescale 1ns/1ps
module dpr_bank #(
	parameter W = 8
) (
	input  wire         pclk,
	input  wire         presetn,
	input  wire         act,
	input  wire         rd,
	input  wire         wr,
	input  wire         ap,
	input  wire         pre,
	input  wire [W-1:0] t_ras,
	input  wire [W-1:0] t_rtp,
	input  wire [W-1:0] t_rp,
	input  wire [W-1:0] rd_ap_dly,
	input  wire [W-1:0] wr_ap_dly,
	output reg          open,
	output wire         precharging
);
	// ****************************************************************
	// Per-bank counters
	// ****************************************************************
	reg [W-1:0] ras_cnt;
	reg [W-1:0] rtp_cnt;
	reg [W-1:0] ap_cnt;
	reg [W-1:0] rp_cnt;
	reg         ap_pend;
	wire        ap_fire;

	// Hold-off until burst, tRAS and tRTP all done
	assign ap_fire = ap_pend && ap_cnt == {W{1'b0}} &&
		ras_cnt == {W{1'b0}} && rtp_cnt == {W{1'b0}};
	assign precharging = rp_cnt != {W{1'b0}};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			open    <= 1'b0;
			ras_cnt <= {W{1'b0}};
			rtp_cnt <= {W{1'b0}};
			ap_cnt  <= {W{1'b0}};
			rp_cnt  <= {W{1'b0}};
			ap_pend <= 1'b0;
		end else begin
			if (ras_cnt != {W{1'b0}})
				ras_cnt <= ras_cnt - 1'b1;
			if (rtp_cnt != {W{1'b0}})
				rtp_cnt <= rtp_cnt - 1'b1;
			if (ap_cnt != {W{1'b0}})
				ap_cnt <= ap_cnt - 1'b1;
			if (rp_cnt != {W{1'b0}})
				rp_cnt <= rp_cnt - 1'b1;
			if (act) begin
				open    <= 1'b1;
				ras_cnt <= t_ras;
			end
			if (rd) begin
				rtp_cnt <= t_rtp;
				if (ap) begin
					ap_pend <= 1'b1;
					ap_cnt  <= rd_ap_dly;
				end
			end
			if (wr && ap) begin
				ap_pend <= 1'b1;
				ap_cnt  <= wr_ap_dly;
			end
			// Latest precharge restarts tRP
			if (pre || ap_fire) begin
				open    <= 1'b0;
				ap_pend <= 1'b0;
				rp_cnt  <= t_rp;
			end
		end
	end
endmodule // dpr_bank

// ==== core/dpr_ctrl.v ====
// Bank-state, refresh and power-down control with an APB register file
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "dpr_defines.vh"
module dpr_ctrl #(
	parameter NB = 4,
	parameter W  = 8
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        cke,
	input  wire        cs_n,
	input  wire        ras_n,
	input  wire        cas_n,
	input  wire        we_n,
	input  wire        a10,
	input  wire [1:0]  ba,
	output reg  [3:0]  bank_open,
	output reg         self_refresh,
	output reg         power_down,
	output reg         active_pd,
	output reg         dll_on,
	output reg         freq_change_ok
);
	// ****************************************************************
	// States
	// ****************************************************************
	localparam [3:0] ST_RUN = 4'h1;
	localparam [3:0] ST_PD  = 4'h2;
	localparam [3:0] ST_SR  = 4'h4;
	localparam [3:0] ST_EX  = 4'h8;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	reg  [6:0] pin_s1;
	reg  [6:0] pin_s2;
	reg        cke_prev;
	wire       s_cke;
	wire       s_cs_n;
	wire       s_ras_n;
	wire       s_cas_n;
	wire       s_we_n;
	wire       s_a10;
	wire [1:0] s_ba;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1   <= 7'h7f;
			pin_s2   <= 7'h7f;
			cke_prev <= 1'b1;
		end else begin
			pin_s1   <= {cke, cs_n, ras_n, cas_n, we_n, a10, ba[1]};
			pin_s2   <= pin_s1;
			cke_prev <= s_cke;
		end
	end
	// Bank bit 0 has its own two-flop chain; ba[1] rides in pin_s1 and pin_s2
	reg ba0_s1;
	reg ba0_s2;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ba0_s1 <= 1'b0;
			ba0_s2 <= 1'b0;
		end else begin
			ba0_s1 <= ba[0];
			ba0_s2 <= ba0_s1;
		end
	end
	assign s_cke   = pin_s2[6];
	assign s_cs_n  = pin_s2[5];
	assign s_ras_n = pin_s2[4];
	assign s_cas_n = pin_s2[3];
	assign s_we_n  = pin_s2[2];
	assign s_a10   = pin_s2[1];
	assign s_ba    = {pin_s2[0], ba0_s2};

	// ****************************************************************
	// Command decode
	// ****************************************************************
	wire sel     = !s_cs_n;
	wire nop     = s_cs_n || (s_ras_n && s_cas_n && s_we_n);
	wire both_hi = cke_prev && s_cke;
	wire c_act   = both_hi && sel && !s_ras_n && s_cas_n && s_we_n;
	wire c_pre   = both_hi && sel && !s_ras_n && s_cas_n && !s_we_n;
	wire c_rd    = both_hi && sel && s_ras_n && !s_cas_n && s_we_n;
	wire c_wr    = both_hi && sel && s_ras_n && !s_cas_n && !s_we_n;
	wire c_mrs   = both_hi && sel && !s_ras_n && !s_cas_n && !s_we_n;
	wire c_ref   = cke_prev && sel && !s_ras_n && !s_cas_n && s_we_n;

	// ****************************************************************
	// Registers
	// ****************************************************************
	reg  [31:0] timing0;
	reg  [31:0] timing1;
	reg  [31:0] ref_count;
	wire [W-1:0] t_ras = timing0[`DPR_F_RAS_LSB +: W];
	wire [W-1:0] t_rtp = timing0[`DPR_F_RTP_LSB +: W];
	wire [W-1:0] t_rp  = timing0[`DPR_F_RP_LSB +: W];
	wire [W-1:0] t_wr  = timing0[`DPR_F_WR_LSB +: W];
	wire [W-1:0] t_al  = timing1[`DPR_F_AL_LSB +: W];
	wire [W-1:0] t_cl  = timing1[`DPR_F_CL_LSB +: W];
	wire         bl8   = timing1[`DPR_F_BL8_BIT];
	wire         fast  = timing1[`DPR_F_FAST_BIT];
	wire [W-1:0] half_bl = bl8 ? 8'd4 : 8'd2;
	// Read AP edge: AL + BL/2; counter reaches zero one edge before it
	wire [W-1:0] rd_ap_dly = t_al + half_bl - 8'd1;
	// Write AP: WL + BL/2 + WR, WL = AL + CL - 1
	wire [W-1:0] wr_ap_dly = t_al + t_cl - 8'd1 + half_bl + t_wr - 8'd1;
	// Last prefetch at AL (BL4) or AL+2 (BL8), plus rtp hold
	wire [W-1:0] rtp_dly = t_al + (bl8 ? 8'd2 : 8'd0) +
		((t_rtp > 8'd2) ? t_rtp : 8'd2) - 8'd1;

	// ****************************************************************
	// Banks
	// ****************************************************************
	wire [NB-1:0] b_open;
	wire [NB-1:0] b_prech;
	reg  [NB-1:0] hit_vec;
	integer       i;

	// Bank select as a vector; the loop index is a plain integer
	always @* begin
		hit_vec = {NB{1'b0}};
		for (i = 0; i < NB; i = i + 1) begin
			if (s_ba == i[1:0])
				hit_vec[i] = 1'b1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NB; g = g + 1) begin : g_bank
			wire hit = hit_vec[g];
			dpr_bank #(.W(W)) u_bank (
				.pclk        (pclk),
				.presetn     (presetn),
				.act         (c_act && hit),
				.rd          (c_rd && hit),
				.wr          (c_wr && hit),
				.ap          (s_a10),
				.pre         (c_pre && (s_a10 || hit)),
				.t_ras       (t_ras),
				.t_rtp       (rtp_dly),
				.t_rp        (t_rp),
				.rd_ap_dly   (rd_ap_dly),
				.wr_ap_dly   (wr_ap_dly),
				.open        (b_open[g]),
				.precharging (b_prech[g])
			);
		end
	endgenerate
	wire all_idle = b_open == {NB{1'b0}};

	// ****************************************************************
	// Power state machine
	// ****************************************************************
	reg [3:0] state;
	reg [3:0] next_state;
	reg [1:0] low_cnt;
	reg       burst_busy;
	reg [W-1:0] burst_cnt;

	// Bursts forbid power-down; track a simple busy window
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			burst_cnt  <= {W{1'b0}};
			burst_busy <= 1'b0;
		end else if (c_rd || c_wr || c_mrs) begin
			burst_cnt  <= wr_ap_dly;
			burst_busy <= 1'b1;
		end else if (burst_cnt != {W{1'b0}}) begin
			burst_cnt <= burst_cnt - 1'b1;
		end else begin
			burst_busy <= 1'b0;
		end
	end

	always @* begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (cke_prev && !s_cke && c_ref && all_idle)
					next_state = ST_SR;
				else if (cke_prev && !s_cke && nop && !burst_busy)
					next_state = ST_PD;
			end
			ST_PD: begin
				if (s_cke && nop)
					next_state = ST_EX;
			end
			ST_SR: begin
				if (s_cke)
					next_state = ST_EX;
			end
			ST_EX: next_state = ST_RUN;
			default: next_state = ST_RUN;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state          <= ST_RUN;
			bank_open      <= 4'h0;
			self_refresh   <= 1'b0;
			power_down     <= 1'b0;
			active_pd      <= 1'b0;
			dll_on         <= 1'b1;
		end else begin
			state        <= next_state;
			bank_open    <= b_open[3:0];
			self_refresh <= next_state == ST_SR;
			power_down   <= next_state == ST_PD;
			if (state == ST_RUN && next_state == ST_PD)
				active_pd <= !all_idle;
			// DLL kept only in fast-exit active power-down
			if (next_state == ST_PD)
				dll_on <= !all_idle && fast;
			else if (next_state == ST_SR)
				dll_on <= 1'b0;
			else
				dll_on <= 1'b1;
		end
	end

	// ****************************************************************
	// Frequency-change gate
	// ****************************************************************
	// Flag only, the device cannot see the clock itself; drops on the
	// exit edge so it never overlaps the way out
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt        <= 2'h0;
			freq_change_ok <= 1'b0;
		end else begin
			if (next_state == ST_PD && !s_cke) begin
				if (low_cnt != 2'h3)
					low_cnt <= low_cnt + 2'h1;
			end else begin
				low_cnt <= 2'h0;
			end
			freq_change_ok <= state == ST_PD && next_state == ST_PD &&
				!active_pd && low_cnt >= `DPR_FREQ_WAIT;
		end
	end

	// ****************************************************************
	// Refresh overdue monitor
	// ****************************************************************
	// Self refresh keeps the age cleared; nine intervals allow for
	// refreshes posted ahead of a long power-down
	reg [15:0] ref_age;
	reg        ref_late;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_age  <= 16'h0000;
			ref_late <= 1'b0;
		end else if (c_ref || state == ST_SR) begin
			ref_age  <= 16'h0000;
			ref_late <= 1'b0;
		end else if (ref_age != `DPR_REF_LIMIT) begin
			ref_age <= ref_age + 16'h0001;
		end else begin
			ref_late <= 1'b1;
		end
	end

	// ****************************************************************
	// Refresh counter and APB slave
	// ****************************************************************
	wire [31:0] status = {16'h0000, 4'h0, b_prech[3:0], 3'h0, ref_late,
		dll_on, active_pd, power_down, self_refresh};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timing0   <= `DPR_RST_TIMING0;
			timing1   <= `DPR_RST_TIMING1;
			ref_count <= 32'h0000_0000;
			prdata    <= 32'h0000_0000;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
		end else begin
			if (c_ref && s_cke)
				ref_count <= ref_count + 32'h0000_0001;
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				case (paddr)
					`DPR_REG_TIMING0: prdata <= timing0;
					`DPR_REG_TIMING1: prdata <= timing1;
					`DPR_REG_STATUS:  prdata <= status;
					`DPR_REG_REFCNT:  prdata <= ref_count;
					default: begin
						prdata  <= 32'h0000_0000;
						pslverr <= 1'b1;
					end
				endcase
			end
			if (psel && penable && pready && pwrite) begin
				case (paddr)
					`DPR_REG_TIMING0: timing0 <= pwdata;
					`DPR_REG_TIMING1: timing1 <= pwdata;
					default: ;
				endcase
			end
		end
	end
endmodule // dpr_ctrl

// ==== sim/dpr_ctrl_properties.sv ====
// Port-level assertions for the bank-state controller
`timescale 1ns/1ps
module dpr_ctrl_properties (
	input wire       pclk,
	input wire       presetn,
	input wire       psel,
	input wire       penable,
	input wire       pready,
	input wire       cke,
	input wire       cs_n,
	input wire       ras_n,
	input wire       cas_n,
	input wire       we_n,
	input wire       a10,
	input wire [1:0] ba,
	input wire [3:0] bank_open,
	input wire       self_refresh,
	input wire       power_down,
	input wire       active_pd,
	input wire       dll_on,
	input wire       freq_change_ok
);
	// ****************************************
	// Pin decode
	// ****************************************
	wire cmd  = cke && !cs_n;
	wire act  = cmd && !ras_n && cas_n && we_n;
	wire pre  = cmd && !ras_n && cas_n && !we_n;
	wire col0 = cmd && ras_n && !cas_n && a10 && ba == 2'h0;
	wire nop  = cs_n || (ras_n && cas_n && we_n);
	wire refc = !cs_n && !ras_n && !cas_n && we_n;
	wire idle = self_refresh || (power_down && !active_pd);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Windows allow for two input flops, the bank flop and the output
	// register
	sequence s_rd_hold;
		##1 bank_open[0] [*6];
	endsequence
	sequence s_wr_hold;
		##4 bank_open[0] [*8];
	endsequence
	a_act_opens_row: assert property (
		act |-> ##4 bank_open[$past(ba, 4)])
		else $error("activate left bank closed");
	a_pre_all_banks: assert property (
		pre && a10 |-> ##4 bank_open == 4'h0)
		else $error("precharge all left a row open");
	a_rd_ap_close: assert property (
		col0 && we_n && $past(bank_open[0], 7) |-> s_rd_hold ##[1:4] !bank_open[0])
		else $error("read auto-precharge timing");
	a_wr_ap_close: assert property (
		col0 && !we_n && bank_open[0] |-> s_wr_hold ##[1:4] !bank_open[0])
		else $error("write auto-precharge timing");
	a_sr_entry: assert property (
		$fell(cke) && refc && bank_open == 4'h0 |-> ##[2:4] self_refresh)
		else $error("self refresh not entered");
	a_pd_entry: assert property (
		$fell(cke) && nop && !self_refresh |-> ##[2:4] power_down)
		else $error("power-down not entered");
	a_dll_off: assert property (
		idle && $past(idle) |-> !dll_on)
		else $error("dll running while idle");
	a_pd_wake: assert property (
		(power_down || self_refresh) && $rose(cke) && nop
		|-> ##[2:4] !(power_down || self_refresh))
		else $error("low-power state not left");
	a_freq_gate: assert property (
		freq_change_ok |-> power_down && !active_pd && $past(power_down))
		else $error("frequency change flagged outside idle power-down");
	a_apb_answer: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("bus answer not one cycle");
endmodule // dpr_ctrl_properties

// ==== sim/dpr_cmd_model.sv ====
// Command-issuing model of the external memory controller
`timescale 1ns/1ps
module dpr_cmd_model (
	input  wire        pclk,
	output logic       cke,
	output logic       cs_n,
	output logic       ras_n,
	output logic       cas_n,
	output logic       we_n,
	output logic       a10,
	output logic [1:0] ba
);
	initial {cke, cs_n, ras_n, cas_n, we_n, a10, ba} = 8'hbf;
	// One command for a clock, then NOP; address lines flip so stale
	// values never look valid
	task automatic cmd(input logic [3:0] c, input logic x,
		input logic [1:0] b, input logic k);
		{cs_n, ras_n, cas_n, we_n} <= c;
		a10 <= x;
		ba <= b;
		cke <= k;
		@(posedge pclk);
		{cs_n, ras_n, cas_n, we_n} <= 4'h7;
		a10 <= ~x;
		ba <= ~b;
		@(posedge pclk);
	endtask
endmodule // dpr_cmd_model

// ==== sim/testbench.sv ====
// Self-checking bench for the bank-state controller
`timescale 1ns/1ps
`include "dpr_defines.vh"
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin \
	error_cnt++; $display("wrong value at %0t: %s", $time, m); end end
module testbench;
	localparam logic [3:0] C_ACT = 4'h3;
	localparam logic [3:0] C_PRE = 4'h2;
	localparam logic [3:0] C_WR  = 4'h4;
	localparam logic [3:0] C_RD  = 4'h5;
	localparam logic [3:0] C_REF = 4'h1;
	localparam logic [3:0] C_NOP = 4'h7;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        err;
	logic        pready, pslverr;
	wire         cke, cs_n, ras_n, cas_n, we_n, a10;
	wire  [1:0]  ba;
	logic [3:0]  bank_open;
	logic        self_refresh, power_down, active_pd, dll_on;
	logic        freq_change_ok;
	integer      error_cnt = 0;
	integer      total_checks = 0;
	always #25 pclk = ~pclk;
	dpr_ctrl i_dpr_ctrl (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .cke, .cs_n, .ras_n,
		.cas_n, .we_n, .a10, .ba, .bank_open, .self_refresh, .power_down,
		.active_pd, .dll_on, .freq_change_ok);
	dpr_cmd_model i_dpr_cmd_model (.pclk, .cke, .cs_n, .ras_n, .cas_n,
		.we_n, .a10, .ba);
	// ****************************************
	// Bus and pin helpers
	// ****************************************
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Look at pready once settled, ahead of the edge it decides
		@(negedge pclk);
		while (pready !== 1'b1) @(negedge pclk);
		rd = prdata;
		err = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic cmd(input logic [3:0] c, input logic x,
		input logic [1:0] b, input logic k);
		i_dpr_cmd_model.cmd(c, x, b, k);
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		`CHK({bank_open, dll_on}, 5'h01, "reset outputs")
		apb(1'b0, `DPR_REG_TIMING0, 32'h0);
		`CHK(rd, `DPR_RST_TIMING0, "timing0 reset")
		apb(1'b1, `DPR_REG_TIMING1, `DPR_RST_TIMING1 | 32'h0002_0000);
		apb(1'b0, `DPR_REG_TIMING1, 32'h0);
		`CHK(rd, `DPR_RST_TIMING1 | 32'h0002_0000, "timing1")
		apb(1'b1, `DPR_REG_STATUS, 32'hffff_ffff);
		apb(1'b0, `DPR_REG_STATUS, 32'h0);
		`CHK(rd[3:0], 4'h8, "status")
		apb(1'b0, 12'h010, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0}, "unmapped")
	endtask
	task automatic t_banks;
		cmd(C_ACT, 1'b0, 2'h0, 1'b1);
		cmd(C_ACT, 1'b0, 2'h1, 1'b1);
		cmd(C_ACT, 1'b0, 2'h2, 1'b1);
		step(10);
		`CHK(bank_open, 4'h7, "activate")
		cmd(C_PRE, 1'b0, 2'h1, 1'b1);
		step(4);
		`CHK(bank_open, 4'h5, "single precharge")
		cmd(C_PRE, 1'b1, 2'h1, 1'b1);
		step(4);
		`CHK(bank_open, 4'h0, "precharge all")
	endtask
	// Second read comes before the row-active minimum has run out
	task automatic t_rd_ap;
		cmd(C_ACT, 1'b0, 2'h0, 1'b1);
		step(12);
		cmd(C_RD, 1'b1, 2'h0, 1'b1);
		step(4);
		`CHK(bank_open[0], 1'b1, "early close")
		step(8);
		`CHK(bank_open[0], 1'b0, "no read auto-precharge")
		cmd(C_ACT, 1'b0, 2'h0, 1'b1);
		cmd(C_RD, 1'b1, 2'h0, 1'b1);
		step(8);
		`CHK(bank_open[0], 1'b1, "row time ignored")
		step(8);
		`CHK(bank_open[0], 1'b0, "delayed close")
	endtask
	task automatic t_wr_ap;
		cmd(C_ACT, 1'b0, 2'h0, 1'b1);
		step(12);
		cmd(C_WR, 1'b1, 2'h0, 1'b1);
		step(10);
		`CHK(bank_open[0], 1'b1, "write closed early")
		step(6);
		`CHK(bank_open[0], 1'b0, "no write auto-precharge")
	endtask
	task automatic t_refresh;
		repeat (3) begin
			cmd(C_REF, 1'b0, 2'h0, 1'b1);
			step(8);
		end
		apb(1'b0, `DPR_REG_REFCNT, 32'h0);
		`CHK(rd, 32'h3, "refresh count")
		cmd(C_REF, 1'b0, 2'h0, 1'b0);
		step(20);
		`CHK({self_refresh, dll_on}, 2'h2, "self refresh")
		cmd(C_NOP, 1'b0, 2'h0, 1'b1);
		step(4);
		`CHK(self_refresh, 1'b0, "self refresh exit")
		step(10);
		cmd(C_REF, 1'b0, 2'h0, 1'b1);
		step(8);
	endtask
	task automatic t_pd;
		cmd(C_NOP, 1'b0, 2'h0, 1'b0);
		step(6);
		`CHK({power_down, active_pd, dll_on}, 3'h4, "idle pd")
		`CHK(freq_change_ok, 1'b1, "frequency gate")
		cmd(C_NOP, 1'b0, 2'h0, 1'b1);
		step(4);
		`CHK(power_down, 1'b0, "pd exit")
		cmd(C_ACT, 1'b0, 2'h3, 1'b1);
		step(4);
		cmd(C_NOP, 1'b0, 2'h0, 1'b0);
		step(6);
		`CHK({active_pd, dll_on, freq_change_ok}, 3'h6, "fast pd")
		cmd(C_NOP, 1'b0, 2'h0, 1'b1);
		step(4);
		apb(1'b1, `DPR_REG_TIMING1, `DPR_RST_TIMING1);
		cmd(C_NOP, 1'b0, 2'h0, 1'b0);
		step(6);
		`CHK({active_pd, dll_on}, 2'h2, "slow pd")
		cmd(C_NOP, 1'b0, 2'h0, 1'b1);
		step(4);
		cmd(C_PRE, 1'b1, 2'h0, 1'b1);
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		step(12);
		presetn <= 1'b1;
		step(1);
		t_regs;
		t_banks;
		t_rd_ap;
		t_wr_ap;
		t_refresh;
		t_pd;
		summarize;
	end
	// Whole run needs some 280 cycles
	initial begin
		step(3000);
		error_cnt++;
		summarize;
	end
endmodule // testbench
bind dpr_ctrl dpr_ctrl_properties i_dpr_ctrl_properties (.pclk, .presetn,
	.psel, .penable, .pready, .cke, .cs_n, .ras_n, .cas_n, .we_n, .a10, .ba,
	.bank_open, .self_refresh, .power_down, .active_pd, .dll_on,
	.freq_change_ok);
